// ==== ctl_model.sv ====
// controller model driving command, address and write data
`timescale 1ns/1ps
`include "sdram_col_defs.vh"
module ctl_model (
  input  wire        clk,
  output reg         cs_n,
  output reg         ras_n,
  output reg         cas_n,
  output reg         we_n,
  output reg  [11:0] addr,
  output reg         dqm,
  output reg  [7:0]  dq_in
);
  initial begin
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    addr = 12'h000;
    // no read is cut by a write, so the mask never has to rise
    dqm = 1'b0;
    dq_in = 8'h00;
  end
  // change after the falling edge, hold across the rising edge
  task op(input [3:0] c, input [11:0] a, input [7:0] d);
    begin
      @(negedge clk);
      {cs_n, ras_n, cas_n, we_n} = c;
      addr = a;
      dq_in = d;
    end
  endtask
  // deselected but with a write pattern; released data shown inverted
  task nop(input integer k);
    integer j;
    begin
      for (j = 0; j < k; j = j + 1) op(4'hc, ~addr, ~dq_in);
    end
  endtask
  task act(input [11:0] a);
    begin
      op(4'h3, a, ~dq_in);
      nop(`RCD_CYC - 1);
    end
  endtask
endmodule

// ==== sdram_burst_addr.v ====
// next burst column from start column, count, length and type
`timescale 1ns/1ps
`include "sdram_col_defs.vh"
module sdram_burst_addr (
  input  wire [9:0] start_col,
  input  wire [9:0] count,
  input  wire [2:0] burst_len,
  input  wire       interleave,
  output reg  [9:0] col
);
  reg [9:0] mask;
  always @* begin
    mask = 10'h000;
    case (burst_len)
      `BL_2:    mask = 10'h001;
      `BL_4:    mask = 10'h003;
      `BL_8:    mask = 10'h007;
      `BL_FULL: mask = 10'h3ff;
      default:  mask = 10'h000;
    endcase
    if (interleave && burst_len != `BL_FULL)
      col = (start_col & ~mask) | ((start_col ^ count) & mask);
    else
      col = (start_col & ~mask) | ((start_col + count) & mask);
  end
endmodule

// ==== sdram_cmd_decode.v ====
// command decoder for the column access block
`timescale 1ns/1ps
`include "sdram_col_defs.vh"
module sdram_cmd_decode (
  input  wire       cs_n,
  input  wire       ras_n,
  input  wire       cas_n,
  input  wire       we_n,
  output reg  [2:0] cmd
);
  always @* begin
    cmd = `CMD_NOP;
    if (!cs_n) begin
      case ({ras_n, cas_n, we_n})
        3'b101:  cmd = `CMD_READ;
        3'b100:  cmd = `CMD_WRITE;
        3'b110:  cmd = `CMD_STOP;
        3'b010:  cmd = `CMD_PRE;
        3'b011:  cmd = `CMD_ACT;
        default: cmd = `CMD_NOP;
      endcase
    end
  end
endmodule

// ==== sdram_col_access.v ====
// column access engine: burst read, write, stop and interrupts for two banks
//
// Behaviour
// - column access only to activated bank; we_n picks direction
// - one word per clock, burst length words
// - burst stays inside aligned column group
// - full page sequential, wraps, runs until ended
// - new command any clock replaces old burst
// - commands every clock, either bank
// - read decode and burst length options
// - first read word after cas latency
// - read interrupts read after latency
// - write data from command clock on
// - ignore data after write burst ends
// - write over write restarts with newest length
// - read ends write on its clock
// - burst stop ends burst, row open
// - stop on read floats after latency
// - stop on write drops stop-clock data
// - precharge to bursting bank ends burst
// - sequential or interleaved order in group
// - column bit ten picks auto precharge
`timescale 1ns/1ps
`include "sdram_col_defs.vh"
module sdram_col_access (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        cs_n,
  input  wire        ras_n,
  input  wire        cas_n,
  input  wire        we_n,
  input  wire [11:0] addr,
  input  wire        dqm,
  input  wire [7:0]  dq_in,
  input  wire [1:0]  cas_latency,
  input  wire [2:0]  burst_len,
  input  wire        interleave,
  output reg  [7:0]  dq_out,
  output reg         dq_oe,
  output reg  [1:0]  bank_open,
  output reg         cmd_error
);
  reg        rst_meta;
  reg        rst_sync;
  wire       rst_n_int;
  wire [2:0] cmd;
  reg  [7:0] mem_a [0:1023];
  reg  [7:0] mem_b [0:1023];
  reg        burst_run;
  reg        burst_write;
  reg        burst_bank;
  reg        burst_ap;
  reg  [9:0] start_col;
  reg  [9:0] count;
  reg  [2:0] blen;
  reg        order_il;
  wire [9:0] cur_col;
  reg  [1:0] rcd_cnt0;
  reg  [1:0] rcd_cnt1;
  reg  [7:0] pipe_d [0:2];
  reg  [2:0] pipe_v;
  reg  [2:0] dqm_d;
  reg  [7:0] rd_word;
  reg        rd_valid;
  reg        last_word;
  wire       is_rw;
  wire       cmd_bank;
  wire       ends_here;
  // counters are two bits wide; the load value of 2 fits, so nothing is cut
  localparam integer RCD_LOAD = `RCD_CYC - 1;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end
  assign rst_n_int = rst_sync;

  sdram_cmd_decode u_dec (
    .cs_n  (cs_n),
    .ras_n (ras_n),
    .cas_n (cas_n),
    .we_n  (we_n),
    .cmd   (cmd)
  );

  sdram_burst_addr u_addr (
    .start_col  (start_col),
    .count      (count),
    .burst_len  (blen),
    .interleave (order_il),
    .col        (cur_col)
  );

  function [9:0] len_words;
    input [2:0] bl;
    begin
      case (bl)
        `BL_1:   len_words = 10'h001;
        `BL_2:   len_words = 10'h002;
        `BL_4:   len_words = 10'h004;
        `BL_8:   len_words = 10'h008;
        default: len_words = 10'h000;
      endcase
    end
  endfunction

  assign is_rw    = (cmd == `CMD_READ) || (cmd == `CMD_WRITE);
  assign cmd_bank = addr[`BANK_BIT];
  // full page never ends by count
  assign ends_here = (blen != `BL_FULL) && (count == len_words(blen) - 10'h001);

  // bank state and row-to-column delay per bank
  always @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      bank_open <= 2'b00;
      rcd_cnt0  <= 2'h0;
      rcd_cnt1  <= 2'h0;
      cmd_error <= 1'b0;
    end else begin
      if (rcd_cnt0 != 2'h0)
        rcd_cnt0 <= rcd_cnt0 - 2'h1;
      if (rcd_cnt1 != 2'h0)
        rcd_cnt1 <= rcd_cnt1 - 2'h1;
      cmd_error <= 1'b0;
      if (cmd == `CMD_ACT) begin
        bank_open[cmd_bank] <= 1'b1;
        if (cmd_bank)
          rcd_cnt1 <= RCD_LOAD[1:0];
        else
          rcd_cnt0 <= RCD_LOAD[1:0];
      end
      if (cmd == `CMD_PRE) begin
        if (addr[`AP_BIT])
          bank_open <= 2'b00;
        else
          bank_open[cmd_bank] <= 1'b0;
      end
      // access to closed bank or before delay is flagged and dropped
      if (is_rw && (!bank_open[cmd_bank] ||
          (cmd_bank ? rcd_cnt1 != 2'h0 : rcd_cnt0 != 2'h0)))
        cmd_error <= 1'b1;
      // auto precharge closes bank at the end of a finite burst longer than one word
      if (burst_run && burst_ap && ends_here && !is_rw)
        bank_open[burst_bank] <= 1'b0;
    end
  end

  wire rw_ok = is_rw && bank_open[cmd_bank] &&
               (cmd_bank ? rcd_cnt1 == 2'h0 : rcd_cnt0 == 2'h0);
  wire pre_hit = (cmd == `CMD_PRE) && (addr[`AP_BIT] || cmd_bank == burst_bank);

  // burst engine
  always @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      burst_run   <= 1'b0;
      burst_write <= 1'b0;
      burst_bank  <= 1'b0;
      burst_ap    <= 1'b0;
      start_col   <= 10'h000;
      count       <= 10'h000;
      blen        <= `BL_1;
      order_il    <= 1'b0;
    end else begin
      if (rw_ok) begin
        // any clock, either bank: new command replaces remaining addresses
        burst_write <= (cmd == `CMD_WRITE);
        burst_bank  <= cmd_bank;
        // full page ignores auto precharge
        burst_ap    <= addr[`AP_BIT] && (burst_len != `BL_FULL);
        start_col   <= addr[9:0];
        blen        <= burst_len;
        order_il    <= interleave && (burst_len != `BL_FULL);
        // write word 0 is stored this clock, so next column is 1
        if (cmd == `CMD_WRITE) begin
          count     <= 10'h001;
          burst_run <= (burst_len != `BL_1);
        end else begin
          // read word 0 is fetched on the command clock as well
          count     <= 10'h001;
          burst_run <= (burst_len != `BL_1);
        end
      end else if (burst_run) begin
        if (cmd == `CMD_STOP || pre_hit || ends_here)
          burst_run <= 1'b0;
        count <= count + 10'h001;
      end
    end
  end

  // write storage: command clock word, then burst words until end or interrupt
  wire [9:0] wr_col  = rw_ok ? addr[9:0] : cur_col;
  wire       wr_bank = rw_ok ? cmd_bank : burst_bank;
  wire       wr_en   = !dqm && (rw_ok ? (cmd == `CMD_WRITE) :
                       (burst_run && burst_write && cmd != `CMD_STOP && !pre_hit &&
                        cmd != `CMD_READ));
  always @(posedge clk) begin
    if (wr_en) begin
      if (wr_bank)
        mem_b[wr_col] <= dq_in;
      else
        mem_a[wr_col] <= dq_in;
    end
  end

  // read fetch: word leaves array one clock after column is known
  wire rd_fetch = (rw_ok && cmd == `CMD_READ) ||
                  (burst_run && !burst_write && !rw_ok &&
                   cmd != `CMD_STOP && !pre_hit);
  wire [9:0] rd_col  = rw_ok ? addr[9:0] : cur_col;
  wire       rd_bank = rw_ok ? cmd_bank : burst_bank;
  always @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      rd_valid <= 1'b0;
      rd_word  <= 8'h00;
    end else begin
      // stop/precharge on a read still drives latency words
      rd_valid <= rd_fetch && (rw_ok || cmd != `CMD_WRITE);
      rd_word  <= rd_bank ? mem_b[rd_col] : mem_a[rd_col];
    end
  end

  // latency pipe: stage k holds a word fetched k+1 clocks ago
  integer i;
  always @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      pipe_v <= 3'h0;
      dqm_d  <= 3'h0;
      for (i = 0; i < 3; i = i + 1)
        pipe_d[i] <= 8'h00;
    end else begin
      pipe_v <= {pipe_v[1:0], rd_valid};
      dqm_d  <= {dqm_d[1:0], dqm};
      pipe_d[0] <= rd_word;
      pipe_d[1] <= pipe_d[0];
      pipe_d[2] <= pipe_d[1];
    end
  end

  // output select by latency; data mask floats outputs one clock later
  reg       sel_v;
  reg [7:0] sel_d;
  always @* begin
    case (cas_latency)
      2'h1: begin
        sel_v = rd_valid;
        sel_d = rd_word;
      end
      2'h2: begin
        sel_v = pipe_v[0];
        sel_d = pipe_d[0];
      end
      `CL_MAX: begin
        sel_v = pipe_v[1];
        sel_d = pipe_d[1];
      end
      default: begin
        sel_v = 1'b0;
        sel_d = 8'h00;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      dq_out <= 8'h00;
      dq_oe  <= 1'b0;
      last_word <= 1'b0;
    end else begin
      dq_out <= sel_d;
      dq_oe  <= sel_v && !dqm_d[0];
      last_word <= sel_v;
    end
  end
endmodule

// ==== sdram_col_access_properties.sv ====
// port assertions for the column access block
`timescale 1ns/1ps
module sdram_col_access_chk (
  input logic        clk,
  input logic        reset_n,
  input logic        cs_n,
  input logic        ras_n,
  input logic        cas_n,
  input logic        we_n,
  input logic [11:0] addr,
  input logic        dqm,
  input logic [1:0]  cas_latency,
  input logic [2:0]  burst_len,
  input logic        dq_oe,
  input logic [1:0]  bank_open,
  input logic        cmd_error
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire rd   = !cs_n && ras_n && !cas_n && we_n && bank_open[addr[11]] && !dqm;
  wire stp  = !cs_n && ras_n && cas_n && !we_n;
  wire pre  = !cs_n && !ras_n && cas_n && !we_n;
  wire idle = cs_n && !dqm;
  property p_cl2;
    (rd && cas_latency == 2'h2) ##1 (!cmd_error && !dqm) ##1 !dqm |=> dq_oe;
  endproperty
  a_cl2: assert property (p_cl2) else $error("first read word missing");
  property p_bl1;
    (rd && cas_latency == 2'h2 && burst_len == 3'h0) ##1 (idle && !cmd_error) ##1 idle [*2]
      |-> dq_oe ##1 !dq_oe;
  endproperty
  a_bl1: assert property (p_bl1) else $error("single word burst wrong length");
  property p_closed;
    !cs_n && ras_n && !cas_n && !bank_open[addr[11]] && $past(reset_n, 3) |=> cmd_error;
  endproperty
  a_closed: assert property (p_closed) else $error("closed bank access not flagged");
  property p_nop;
    cs_n |=> !cmd_error;
  endproperty
  a_nop: assert property (p_nop) else $error("deselected cycle decoded");
  property p_stop_float;
    (stp && cas_latency == 2'h1) ##1 cs_n |-> ##2 !dq_oe;
  endproperty
  a_stop_float: assert property (p_stop_float) else $error("data after stop");
  property p_stop_open;
    stp |=> bank_open == $past(bank_open);
  endproperty
  a_stop_open: assert property (p_stop_open) else $error("stop changed bank state");
  property p_pre_one;
    pre && !addr[10] && !addr[11] |=> !bank_open[0];
  endproperty
  a_pre_one: assert property (p_pre_one) else $error("bank stayed open");
  property p_pre_all;
    pre && addr[10] |=> bank_open == 2'h0;
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("banks stayed open");
endmodule
bind sdram_col_access sdram_col_access_chk sdram_col_access_chk_inst (.clk, .reset_n, .cs_n,
  .ras_n, .cas_n, .we_n, .addr, .dqm, .cas_latency, .burst_len, .dq_oe, .bank_open, .cmd_error);

// ==== sdram_col_defs.vh ====
// constants for the sdram column access block
`ifndef SDRAM_COL_DEFS_VH
`define SDRAM_COL_DEFS_VH
`define COL_W        10
`define DATA_W       8
`define BL_1         3'h0
`define BL_2         3'h1
`define BL_4         3'h2
`define BL_8         3'h3
`define BL_FULL      3'h7
`define PAGE_LAST    10'h3ff
`define CL_MAX       2'h3
`define AP_BIT       10
`define BANK_BIT     11
`define CMD_NOP      3'h0
`define CMD_READ     3'h1
`define CMD_WRITE    3'h2
`define CMD_STOP     3'h3
`define CMD_PRE      3'h4
`define CMD_ACT      3'h5
`define RCD_NS       20
`define CLK_NS       8
`define RCD_CYC      ((`RCD_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ==== tb_top.sv ====
// bench for the column access block
`timescale 1ns/1ps
`include "sdram_col_defs.vh"
module tb_top;
  reg         clk;
  reg         reset_n;
  reg  [1:0]  cas_latency;
  reg  [2:0]  burst_len;
  reg         interleave;
  wire        cs_n, ras_n, cas_n, we_n, dqm, dq_oe, cmd_error;
  wire [11:0] addr;
  wire [7:0]  dq_in, dq_out;
  wire [1:0]  bank_open;
  integer     errors = 0, compares = 0, cycles = 0, n = 0, t0 = 0, tc = 0, i;
  reg  [7:0]  got [0:15];
  ctl_model ctl_model_inst (.clk, .cs_n, .ras_n, .cas_n, .we_n, .addr, .dqm, .dq_in);
  sdram_col_access sdram_col_access_inst (.clk, .reset_n, .cs_n, .ras_n, .cas_n, .we_n,
    .addr, .dqm, .dq_in, .cas_latency, .burst_len, .interleave, .dq_out, .dq_oe, .bank_open,
    .cmd_error);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
      errors = errors + 1;
      final_report;
    end
    #2;
    if (dq_oe === 1'b1) begin
      if (n == 0) t0 = cycles;
      if (n < 16) got[n] = dq_out;
      n = n + 1;
    end
  end
  task final_report;
    begin
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk_w(input [7:0] g, input [7:0] e);
    begin
      compares = compares + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("Error %0t word %h not %h", $time, g, e);
      end
    end
  endtask
  task chk_n(input integer g, input integer e);
    begin
      compares = compares + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("Error %0t count %0d not %0d", $time, g, e);
      end
    end
  endtask
  task words(input integer c, input [63:0] e);
    begin
      chk_n(n, c);
      for (i = 0; i < c; i = i + 1) chk_w(got[i], e[63-8*i -: 8]);
    end
  endtask
  task op(input [3:0] c, input [11:0] a, input [7:0] d);
    ctl_model_inst.op(c, a, d);
  endtask
  task nop(input integer k);
    ctl_model_inst.nop(k);
  endtask
  task wr(input [11:0] a, input [7:0] d, input integer len);
    begin
      op(4'h4, a, d);
      for (i = 1; i < len; i = i + 1) op(4'hf, a, d + i[7:0]);
    end
  endtask
  task rd(input [11:0] a, input [1:0] cl, input [2:0] bl);
    begin
      cas_latency = cl;
      burst_len = bl;
      n = 0;
      op(4'h5, a, ~dq_in);
      tc = cycles;
    end
  endtask
  task t_seq_il;
    begin
      ctl_model_inst.act(12'h000);
      wr(12'h000, 8'h10, 8);
      rd(12'h005, 2'h2, `BL_4);
      nop(8);
      chk_n(t0, tc + 3);
      words(4, 64'h15161714_00000000);
      interleave = 1'b1;
      rd(12'h005, 2'h3, `BL_8);
      nop(12);
      chk_n(t0, tc + 4);
      words(8, 64'h15141716_11101312);
      interleave = 1'b0;
      $display("sequential and interleaved done");
    end
  endtask
  task t_rr_stop;
    begin
      rd(12'h000, 2'h1, `BL_4);
      nop(1);
      op(4'h5, 12'h004, 8'h00);
      nop(8);
      words(6, 64'h10111415_16170000);
      rd(12'h000, 2'h1, `BL_8);
      nop(1);
      op(4'h6, 12'h000, 8'h00);
      nop(6);
      words(2, 64'h10110000_00000000);
      rd(12'h003, 2'h2, `BL_1);
      nop(6);
      words(1, 64'h13000000_00000000);
      $display("interrupt and stop done");
    end
  endtask
  task t_page;
    begin
      burst_len = `BL_FULL;
      wr(12'h3fe, 8'ha0, 4);
      op(4'h6, 12'h000, 8'hee);
      rd(12'h3fe, 2'h2, `BL_FULL);
      nop(4);
      op(4'h6, 12'h000, 8'h00);
      nop(8);
      words(5, 64'ha0a1a2a3_12000000);
      $display("full page done");
    end
  endtask
  task t_wr;
    begin
      burst_len = `BL_8;
      ctl_model_inst.act(12'h800);
      wr(12'h808, 8'h40, 8);
      burst_len = `BL_4;
      wr(12'h808, 8'h20, 2);
      wr(12'h80c, 8'h30, 2);
      rd(12'h808, 2'h2, `BL_8);
      nop(12);
      words(8, 64'h20214243_30314647);
      $display("write interrupts done");
    end
  endtask
  task t_pre;
    begin
      rd(12'h000, 2'h1, `BL_8);
      nop(2);
      op(4'h2, 12'h000, 8'h00);
      nop(6);
      words(3, 64'ha2a31200_00000000);
      chk_w({6'h00, bank_open}, 8'h02);
      rd(12'h000, 2'h1, `BL_8);
      nop(6);
      chk_n(n, 0);
      op(4'h2, 12'h400, 8'h00);
      nop(2);
      chk_w({6'h00, bank_open}, 8'h00);
      $display("precharge done");
    end
  endtask
  initial begin
    reset_n = 1'b0;
    cas_latency = 2'h2;
    burst_len = `BL_8;
    interleave = 1'b0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    nop(3);
    t_seq_il;
    t_rr_stop;
    t_page;
    t_wr;
    t_pre;
    final_report;
  end
endmodule
